/* verilog/cxw_map.vh */
`ifndef CXW_MAP_VH
`define CXW_MAP_VH

// ----------------------------------------
// opcode encodings (6-bit high fields for swaps, 10-bit words for watchdog ops)
// ----------------------------------------
`define CXW_OP_SWAP_HI      6'h2d
`define CXW_OP_SWAP_DEC_HI  6'h2f
`define CXW_OP_WD_RESTART   10'h0a0
`define CXW_OP_WD_STOP      10'h3fe

// ----------------------------------------
// field positions
// ----------------------------------------
`define CXW_IMM_MSB         3
`define CXW_HI_LSB          4
`define CXW_HI_MSB          9

// ----------------------------------------
// reset values and column underflow value
// ----------------------------------------
`define CXW_RST_NIBBLE      4'h0
`define CXW_RST_FLAG        1'b0
`define CXW_RST_WD_RUN      1'b1
`define CXW_UNDERFLOW       4'hf

`endif

/* verilog/cxw_decode.v */
`timescale 1ns/1ps
`include "cxw_map.vh"

module cxw_decode (
    input  wire [9:0] instr_i,
    output wire       is_swap_o,
    output wire       is_swap_dec_o,
    output wire       is_wd_restart_o,
    output wire       is_wd_stop_o,
    output wire [3:0] imm_o
);
    assign is_swap_o       =
        (instr_i[`CXW_HI_MSB:`CXW_HI_LSB] == `CXW_OP_SWAP_HI);
    assign is_swap_dec_o   =
        (instr_i[`CXW_HI_MSB:`CXW_HI_LSB] == `CXW_OP_SWAP_DEC_HI);
    assign is_wd_restart_o = (instr_i == `CXW_OP_WD_RESTART);
    assign is_wd_stop_o    = (instr_i == `CXW_OP_WD_STOP);
    assign imm_o           = instr_i[`CXW_IMM_MSB:0];
endmodule

/* verilog/cxw_exec.v */
// Function
// - restart op skips next when first watchdog flag set, then clears it
// - swap op exchanges accumulator with memory word at data pointer
// - row register takes its xor with the 4-bit immediate during swaps
// - swap-decrement op swaps, xors row, then decrements column register
// - after decrement, column equal to 15 skips the next instruction
`timescale 1ns/1ps
`include "cxw_map.vh"

module cxw_exec (
    input  wire       mclk_i,
    input  wire       rst_i,
    input  wire       ce_i,
    input  wire       instr_valid_i,
    input  wire [9:0] instr_i,
    input  wire [3:0] mem_rdata_i,
    input  wire       wd_flag_set_i,
    input  wire [3:0] acc_load_i,
    input  wire       acc_load_en_i,
    output reg  [3:0] acc_o,
    output reg  [3:0] row_o,
    output reg  [3:0] col_o,
    output reg  [3:0] mem_wdata_o,
    output reg        mem_we_o,
    output reg        skip_o,
    output reg        watchdog_flag_first_o,
    output reg        wd_restart_o,
    output reg        wd_run_o
);

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire       is_swap;
    wire       is_swap_dec;
    wire       is_wd_restart;
    wire       is_wd_stop;
    wire [3:0] imm;

    cxw_decode u_dec (
        .instr_i         (instr_i),
        .is_swap_o       (is_swap),
        .is_swap_dec_o   (is_swap_dec),
        .is_wd_restart_o (is_wd_restart),
        .is_wd_stop_o    (is_wd_stop),
        .imm_o           (imm)
    );

    // ----------------------------------------
    // slot qualification
    // ----------------------------------------
    // a skipped slot executes nothing, including these ops
    wire       exec;
    wire       do_swap;
    wire       do_dec;
    wire       do_watchdog_restart_op;
    wire       do_stop;
    wire [3:0] dec_col;
    wire       underflow;
    reg        prev_stop;

    assign exec      = ce_i & instr_valid_i & ~skip_o;
    assign do_swap   = exec & (is_swap | is_swap_dec);
    assign do_dec    = exec & is_swap_dec;
    assign do_watchdog_restart_op   = exec & is_wd_restart;
    assign do_stop   = exec & is_wd_stop;
    assign dec_col   = col_o - 4'h1;
    assign underflow = (dec_col == `CXW_UNDERFLOW);

    // ----------------------------------------
    // next values
    // ----------------------------------------
    reg  [3:0] next_acc;
    reg  [3:0] next_row;
    reg  [3:0] next_col;
    reg  [3:0] next_mem_wdata;
    reg        next_mem_we;
    reg        next_skip;
    reg        next_flag;
    reg        next_wd_restart;
    reg        next_wd_run;
    reg        next_prev_stop;

    // ----------------------------------------
    // accumulator and memory write
    // ----------------------------------------
    // swap outranks the outside load, so the old value
    // still reaches memory when both land together
    always @* begin
        next_acc       = acc_o;
        next_mem_wdata = mem_wdata_o;
        next_mem_we    = 1'b0;
        if (do_swap) begin
            next_acc       = mem_rdata_i;
            next_mem_wdata = acc_o;
            next_mem_we    = 1'b1;
        end else if (acc_load_en_i) begin
            next_acc = acc_load_i;
        end
    end

    // ----------------------------------------
    // row register
    // ----------------------------------------
    always @* begin
        next_row = row_o;
        if (do_swap) begin
            next_row = row_o ^ imm;
        end
    end

    // ----------------------------------------
    // column register
    // ----------------------------------------
    always @* begin
        next_col = col_o;
        if (do_dec) begin
            next_col = dec_col;
        end
    end

    // ----------------------------------------
    // skip slot
    // ----------------------------------------
    // skip stands across idle cycles until a valid word uses it up
    always @* begin
        next_skip = skip_o;
        if (instr_valid_i) begin
            next_skip = 1'b0;
        end
        if (do_dec && underflow) begin
            next_skip = 1'b1;
        end
        if (do_watchdog_restart_op && watchdog_flag_first_o) begin
            next_skip = 1'b1;
        end
    end

    // ----------------------------------------
    // first watchdog flag
    // ----------------------------------------
    // set wins over the restart clear, so a flag raised in the
    // same cycle is not lost
    always @* begin
        next_flag = watchdog_flag_first_o;
        if (wd_flag_set_i) begin
            next_flag = 1'b1;
        end else if (do_watchdog_restart_op) begin
            next_flag = 1'b0;
        end
    end

    // ----------------------------------------
    // watchdog run and restart
    // ----------------------------------------
    // a stop in a skipped slot does not arm the halt
    always @* begin
        next_wd_restart = 1'b0;
        next_wd_run     = wd_run_o;
        next_prev_stop  = prev_stop;
        if (instr_valid_i) begin
            next_prev_stop = do_stop;
        end
        if (do_watchdog_restart_op) begin
            if (prev_stop) begin
                next_wd_run = 1'b0;
            end else begin
                next_wd_restart = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // datapath registers
    // ----------------------------------------
    // clock enable low freezes every register, pulses included
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_o <= `CXW_RST_NIBBLE;
            row_o <= `CXW_RST_NIBBLE;
            col_o <= `CXW_RST_NIBBLE;
        end else if (ce_i) begin
            acc_o <= next_acc;
            row_o <= next_row;
            col_o <= next_col;
        end
    end

    // ----------------------------------------
    // memory write port
    // ----------------------------------------
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_wdata_o <= `CXW_RST_NIBBLE;
            mem_we_o    <= 1'b0;
        end else if (ce_i) begin
            mem_wdata_o <= next_mem_wdata;
            mem_we_o    <= next_mem_we;
        end
    end

    // ----------------------------------------
    // skip and watchdog registers
    // ----------------------------------------
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            skip_o                <= 1'b0;
            watchdog_flag_first_o <= `CXW_RST_FLAG;
            wd_restart_o          <= 1'b0;
            wd_run_o              <= `CXW_RST_WD_RUN;
            prev_stop             <= 1'b0;
        end else if (ce_i) begin
            skip_o                <= next_skip;
            watchdog_flag_first_o <= next_flag;
            wd_restart_o          <= next_wd_restart;
            wd_run_o              <= next_wd_run;
            prev_stop             <= next_prev_stop;
        end
    end

endmodule

/* bench/cxw_exec_props.sv */
`timescale 1ns/1ps
module cxw_exec_props (
    input wire       mclk_i,
    input wire       rst_i,
    input wire       ce_i,
    input wire       instr_valid_i,
    input wire       wd_flag_set_i,
    input wire       skip_o,
    input wire       watchdog_flag_first_o,
    input wire       wd_run_o,
    input wire       mem_we_o,
    input wire [9:0] instr_i,
    input wire [3:0] mem_rdata_i,
    input wire [3:0] acc_o,
    input wire [3:0] row_o,
    input wire [3:0] col_o,
    input wire [3:0] mem_wdata_o
);
    wire tk = ce_i & instr_valid_i & ~skip_o;
    wire sw = tk & (instr_i[9:6] == 4'hb) & instr_i[4];
    wire rs = tk & (instr_i == 10'h0a0);
    reg  ps;
    // a stop in a skipped slot does not arm the halt
    always @(posedge mclk_i or posedge rst_i)
        if (rst_i) ps <= 1'h0;
        else if (ce_i & instr_valid_i) ps <= tk & (instr_i == 10'h3fe);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    chk_acc_swap: assert property (sw |=> acc_o == $past(mem_rdata_i))
        else $error("acc swap wrong");
    chk_row_xor: assert property (sw |=> row_o ==
        ($past(row_o) ^ $past(instr_i[3:0]))) else $error("row wrong");
    chk_col_dec: assert property (sw & instr_i[5] |=>
        col_o == $past(col_o) - 4'h1) else $error("col wrong");
    chk_dec_skip: assert property (sw & instr_i[5] |=>
        skip_o == ($past(col_o) == 4'h0)) else $error("dec skip wrong");
    chk_wd_skip: assert property (rs & ~ps |=>
        skip_o == $past(watchdog_flag_first_o)) else $error("wd skip wrong");
    chk_wd_halt: assert property (rs & ps |=> !wd_run_o)
        else $error("wd not halted");
    chk_mem_write: assert property (sw |=> mem_we_o &&
        mem_wdata_o == $past(acc_o)) else $error("mem write wrong");
    chk_flag_clear: assert property (rs & ~wd_flag_set_i |=>
        !watchdog_flag_first_o) else $error("flag not cleared");
endmodule
bind cxw_exec cxw_exec_props cxw_exec_props_i (
    .mclk_i                (mclk_i),
    .rst_i                 (rst_i),
    .ce_i                  (ce_i),
    .instr_valid_i         (instr_valid_i),
    .wd_flag_set_i         (wd_flag_set_i),
    .skip_o                (skip_o),
    .watchdog_flag_first_o (watchdog_flag_first_o),
    .wd_run_o              (wd_run_o),
    .mem_we_o              (mem_we_o),
    .instr_i               (instr_i),
    .mem_rdata_i           (mem_rdata_i),
    .acc_o                 (acc_o),
    .row_o                 (row_o),
    .col_o                 (col_o),
    .mem_wdata_o           (mem_wdata_o)
);

/* bench/tb_cxw_exec.sv */
`timescale 1ns/1ps
module tb_cxw_exec;
    reg        mclk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1;
    reg        instr_valid_i = 1'h0, wd_flag_set_i = 1'h0;
    reg        acc_load_en_i = 1'h0;
    reg  [9:0] instr_i = 10'h000;
    reg  [3:0] mem_rdata_i = 4'h0, acc_load_i = 4'h0;
    wire [3:0] acc_o, row_o, col_o, mem_wdata_o;
    wire       skip_o, watchdog_flag_first_o, wd_restart_o, wd_run_o;
    wire       mem_we_o;
    integer    fail_count = 0, total_checks = 0, cyc = 0;
    always #2 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (++cyc == 2000) wrap_up(1);
    cxw_exec cxw_exec_i (
        .mclk_i                (mclk_i),
        .rst_i                 (rst_i),
        .ce_i                  (ce_i),
        .instr_valid_i         (instr_valid_i),
        .instr_i               (instr_i),
        .mem_rdata_i           (mem_rdata_i),
        .wd_flag_set_i         (wd_flag_set_i),
        .acc_load_i            (acc_load_i),
        .acc_load_en_i         (acc_load_en_i),
        .acc_o                 (acc_o),
        .row_o                 (row_o),
        .col_o                 (col_o),
        .mem_wdata_o           (mem_wdata_o),
        .mem_we_o              (mem_we_o),
        .skip_o                (skip_o),
        .watchdog_flag_first_o (watchdog_flag_first_o),
        .wd_restart_o          (wd_restart_o),
        .wd_run_o              (wd_run_o)
    );
    task cmp(input [63:0] nm, input [11:0] e, g);
        total_checks++;
        fail_count += (g !== e);
        if (g !== e) $display("[ERR] %0s exp %h got %h", nm, e, g);
    endtask
    task op(input [9:0] w, input [3:0] m = 4'h0, input v = 1'h1, f = 1'h0);
        @(posedge mclk_i);
        {instr_i, mem_rdata_i, instr_valid_i, wd_flag_set_i} <= {w, m, v, f};
        @(posedge mclk_i) {instr_valid_i, wd_flag_set_i} <= 2'h0;
        @(negedge mclk_i);
    endtask
    task t_swap;
        op(10'h2f3, 4'h3);
        cmp("mem", 12'h010, {7'h0, mem_we_o, mem_wdata_o});
        cmp("skip", 12'h001, {11'h0, skip_o});
        op(10'h2d1, 4'h9);
        cmp("arc", 12'h33f, {acc_o, row_o, col_o});
        cmp("mem", 12'h000, {7'h0, mem_we_o, mem_wdata_o});
        op(10'h2d5, 4'ha);
        cmp("arc", 12'ha6f, {acc_o, row_o, col_o});
        cmp("mem", 12'h013, {7'h0, mem_we_o, mem_wdata_o});
        op(10'h2fc, 4'h7);
        cmp("arc", 12'h7ae, {acc_o, row_o, col_o});
        cmp("skip", 12'h000, {11'h0, skip_o});
        op(10'h2d0, 4'h1);
        cmp("arc", 12'h1ae, {acc_o, row_o, col_o});
        $display("swap test done");
    endtask
    task t_ce;
        @(posedge mclk_i) ce_i <= 1'h0;
        op(10'h2d7, 4'h5);
        cmp("frz", 12'h1ae, {acc_o, row_o, col_o});
        @(posedge mclk_i) ce_i <= 1'h1;
        @(posedge mclk_i) {acc_load_i, acc_load_en_i} <= {4'h9, 1'h1};
        @(posedge mclk_i) acc_load_en_i <= 1'h0;
        @(negedge mclk_i);
        cmp("load", 12'h9ae, {acc_o, row_o, col_o});
        $display("enable test done");
    endtask
    task t_wd;
        op(10'h0a0);
        cmp("wd", 12'h003, {8'h0, skip_o, watchdog_flag_first_o,
            wd_restart_o, wd_run_o});
        op(10'h000, 4'h0, 1'h0, 1'h1);
        op(10'h0a0);
        cmp("wd", 12'h00b, {8'h0, skip_o, watchdog_flag_first_o,
            wd_restart_o, wd_run_o});
        op(10'h3fe);
        op(10'h3fe);
        op(10'h0a0);
        cmp("wd", 12'h000, {8'h0, skip_o, watchdog_flag_first_o,
            wd_restart_o, wd_run_o});
        op(10'h0a0, 4'h0, 1'h1, 1'h1);
        cmp("wd", 12'h006, {8'h0, skip_o, watchdog_flag_first_o,
            wd_restart_o, wd_run_o});
        $display("wd test done");
    endtask
    task t_rst;
        @(posedge mclk_i) rst_i <= 1'h1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'h0;
        @(negedge mclk_i);
        cmp("arc", 12'h000, {acc_o, row_o, col_o});
        cmp("wd", 12'h001, {8'h0, skip_o, watchdog_flag_first_o,
            wd_restart_o, wd_run_o});
        cmp("mem", 12'h000, {7'h0, mem_we_o, mem_wdata_o});
        op(10'h2d3, 4'h4);
        cmp("arc", 12'h430, {acc_o, row_o, col_o});
        $display("reset test done");
    endtask
    task wrap_up(input integer to);
        fail_count += to;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'h0;
        t_swap;
        t_ce;
        t_wd;
        t_rst;
        wrap_up(0);
    end
endmodule
